// file: logic/serial_controller.v
// Memory-mapped synchronous serial controller, master or slave
// Notes on behaviour
// - Completed word into receive holding sets full flag and full request
// - Word completing before read overwrites, sets overflow flag and request
// - Serial input shifts in MSB first, high level stored as one
// - Mask count clears that many upper bits on loading a received word
// - Receive holding is read-only; writes do not change it
// - Master mode: writing transmit holding starts a transfer
// - Slave mode: transmit word loads into shifter on first remote clock
// - Transmit word moving to shifter sets empty request; empty flag only once the queue is drained
// - Serial output driven MSB first, one high, zero low
// - Bits per transfer equal the length field plus one
// - Short words send only the low-order bits of transmit holding
// - Master clock rate is system clock over four times two^rate field
// - Phase and polarity bits set clock timing, both reset to zero
// - Reserved bits are written zero and read back as zero
// - Eight word registers decode at consecutive word addresses
// - Enable bit runs the controller; clearing it stops operation
// - Mode bit set makes master clock, clear uses remote clock
// - Reading receive holding clears full and overflow flags
// - Busy covers transfer and wait in master; zero in slave
`timescale 1ns/1ps
`include "serial_ctl_map.vh"
module serial_controller #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Register port, word accesses only
  input  wire [23:0] reg_addr,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  // Serial link
  input  wire        serial_in_pin,
  output reg         serial_out_pin,
  output reg         serial_clock_out,
  output reg         serial_clock_oe_n,
  input  wire        serial_clock_in,
  // Requests
  output reg         interrupt_request,
  output reg         tx_dma_request,
  output reg         rx_dma_request
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_WAIT  = 3'b100;

  reg [31:0] receive_holding;
  reg [31:0] transfer_setup;
  reg [31:0] slave_select_control;
  reg [31:0] interword_wait;
  reg [31:0] interrupt_setup;
  reg [31:0] receive_bit_mask;
  reg        rx_full_flag;
  reg        rx_overflow_flag;
  reg        tx_empty_flag;
  reg        transfer_busy_flag;
  reg [2:0]  state;
  reg [31:0] shifter;
  reg [5:0]  bit_count;
  reg [9:0]  div_count;
  reg [31:0] wait_count;
  reg        sclk_phase;
  reg        clk_in_last;
  reg        rx_done;
  reg        tx_taken;
  reg [31:0] next_rdata;

  wire       controller_enable_bit = transfer_setup[`SETUP_ENABLE_BIT];
  wire       master_mode           = transfer_setup[`SETUP_MODE_BIT];
  wire       clock_phase_select    = transfer_setup[`SETUP_PHASE_BIT];
  wire       clock_polarity_select = transfer_setup[`SETUP_POLARITY_BIT];
  wire [2:0] clock_rate_field =
             transfer_setup[`SETUP_RATE_MSB:`SETUP_RATE_LSB];
  wire [4:0] word_length_field =
             transfer_setup[`SETUP_LENGTH_MSB:`SETUP_LENGTH_LSB];
  wire [5:0] word_bits = {1'b0, word_length_field} + 6'h01;
  wire       slave_selected = slave_select_control[`SELECT_BIT];

  // Transmit words queue in the FIFO ahead of the shifter; its head is the transmit holding
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [31:0] fifo_out_data;
  wire        write_tx = reg_write && reg_addr == `TRANSMIT_HOLDING_ADDR;
  wire        fifo_pop;
  word_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) tx_queue (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (write_tx),
    .in_ready  (fifo_in_ready),
    .in_data   (reg_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial clock edges
  // Half period is 2 * 2^rate system clocks: full period 4 * 2^rate
  wire [9:0] half_period =
             {7'h00, `BASE_DIVIDE_HALF} << clock_rate_field;
  wire       master_tick = (div_count == half_period - 10'h001);
  // Remote clock, normalised so rise means the leading edge
  wire       rem_lead  = (serial_clock_in ^ clock_polarity_select) &
                         !(clk_in_last ^ clock_polarity_select);
  wire       rem_trail = !(serial_clock_in ^ clock_polarity_select) &
                         (clk_in_last ^ clock_polarity_select);
  wire       slave_on  = controller_enable_bit && !master_mode &&
                         slave_selected;
  wire       lead_edge  = master_mode ? (master_tick && !sclk_phase) :
                          (slave_on && rem_lead);
  wire       trail_edge = master_mode ? (master_tick && sclk_phase) :
                          (slave_on && rem_trail);
  // Phase 0 samples on the leading edge, phase 1 on the trailing one
  wire       sample_edge = clock_phase_select ? trail_edge : lead_edge;
  wire       change_edge = clock_phase_select ? lead_edge : trail_edge;

  // Word aligned so its top bit leaves first; only low bits go out
  wire [31:0] tx_aligned = fifo_out_data << (6'd32 - word_bits);
  wire        start_master = controller_enable_bit && master_mode &&
                             state == ST_IDLE && fifo_out_valid;
  // Every slave word opens on a leading edge; the trailing edge after the
  // last sample must not start a phantom word
  wire        start_slave  = slave_on && state == ST_IDLE &&
                             rem_lead;
  assign fifo_pop = start_master || (start_slave && fifo_out_valid);

  // Mask clears the upper count bits; count zero keeps all
  wire [5:0]  mask_count = receive_bit_mask[`MASK_COUNT_MSB:0];
  wire [31:0] keep_mask  = (mask_count >= 6'd32) ? 32'h00000000 :
                           (32'hffffffff >> mask_count);
  // Received bits sit in the low end; leftover transmit bits above
  wire [31:0] width_mask = 32'hffffffff >> (6'd32 - word_bits);
  wire [31:0] rx_word    = shifter & width_mask & keep_mask;
  wire        last_bit   = sample_edge && bit_count == word_bits - 6'h01;
  wire        read_rx    = reg_read && reg_addr == `RECEIVE_HOLDING_ADDR;

  ////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always @(posedge clock) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      shifter            <= `WORD_RESET;
      bit_count          <= 6'h00;
      div_count          <= 10'h000;
      wait_count         <= `WORD_RESET;
      sclk_phase         <= 1'b0;
      clk_in_last        <= 1'b0;
      rx_done            <= 1'b0;
      tx_taken           <= 1'b0;
      transfer_busy_flag <= 1'b0;
      serial_out_pin     <= 1'b0;
      serial_clock_out   <= 1'b0;
      serial_clock_oe_n  <= 1'b1;
    end else begin
      clk_in_last <= serial_clock_in;
      rx_done     <= 1'b0;
      tx_taken    <= 1'b0;
      serial_clock_oe_n <= !(controller_enable_bit && master_mode);
      if (!controller_enable_bit) begin
        state              <= ST_IDLE;
        div_count          <= 10'h000;
        sclk_phase         <= 1'b0;
        transfer_busy_flag <= 1'b0;
        serial_clock_out   <= clock_polarity_select;
      end else begin
        if (state != ST_IDLE && master_mode)
          div_count <= master_tick ? 10'h000 : div_count + 10'h001;
        case (state)
          ST_IDLE: begin
            div_count  <= 10'h000;
            sclk_phase <= 1'b0;
            serial_clock_out <= clock_polarity_select;
            bit_count  <= 6'h00;
            if (start_master || start_slave) begin
              shifter  <= fifo_out_valid ? tx_aligned : `WORD_RESET;
              tx_taken <= fifo_out_valid;
              // Phase 0 master presents the first bit before any edge; a slave only on its first leading edge
              serial_out_pin <= fifo_out_valid ? tx_aligned[31] :
                                1'b0;
              state <= ST_SHIFT;
              transfer_busy_flag <= master_mode;
              if (start_slave && rem_lead && !clock_phase_select)
                shifter <= {(fifo_out_valid ? tx_aligned[30:0] : 31'h0),
                            serial_in_pin};
              if (start_slave && rem_lead && !clock_phase_select)
                bit_count <= 6'h01;
            end
          end
          ST_SHIFT: begin
            if (master_mode && master_tick) begin
              sclk_phase       <= !sclk_phase;
              serial_clock_out <= !serial_clock_out;
            end
            if (change_edge && !(clock_phase_select == 1'b0 &&
                                 bit_count == 6'h00))
              serial_out_pin <= shifter[31];
            if (sample_edge) begin
              shifter   <= {shifter[30:0], serial_in_pin};
              bit_count <= bit_count + 6'h01;
            end
            if (last_bit) begin
              rx_done <= 1'b1;
              if (master_mode) begin
                state      <= ST_WAIT;
                wait_count <= interword_wait;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_WAIT: begin
            // Let the clock return to idle level before counting
            if (master_tick) begin
              sclk_phase       <= !sclk_phase;
              if (sclk_phase)
                serial_clock_out <= !serial_clock_out;
              if (!sclk_phase) begin
                if (wait_count == `WORD_RESET) begin
                  state              <= ST_IDLE;
                  transfer_busy_flag <= 1'b0;
                end else begin
                  wait_count <= wait_count - 32'h00000001;
                end
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and flags
  always @(posedge clock) begin
    if (!rst_n) begin
      receive_holding      <= `WORD_RESET;
      transfer_setup       <= `WORD_RESET;
      slave_select_control <= `WORD_RESET;
      interword_wait       <= `WORD_RESET;
      interrupt_setup      <= `WORD_RESET;
      receive_bit_mask     <= `WORD_RESET;
      rx_full_flag         <= 1'b0;
      rx_overflow_flag     <= 1'b0;
      tx_empty_flag        <= 1'b1;
      interrupt_request    <= 1'b0;
      tx_dma_request       <= 1'b0;
      rx_dma_request       <= 1'b0;
      reg_rdata            <= `WORD_RESET;
    end else begin
      reg_rdata <= next_rdata;
      if (reg_write) begin
        case (reg_addr)
          `TRANSFER_SETUP_ADDR:
            transfer_setup <= reg_wdata & `SETUP_WRITE_MASK;
          `SLAVE_SELECT_CONTROL_ADDR:
            slave_select_control <= reg_wdata & `SELECT_WRITE_MASK;
          `INTERWORD_WAIT_ADDR:
            interword_wait <= reg_wdata;
          `INTERRUPT_SETUP_ADDR:
            interrupt_setup <= reg_wdata & `INT_WRITE_MASK;
          `RECEIVE_BIT_MASK_ADDR:
            receive_bit_mask <= reg_wdata & `MASK_WRITE_MASK;
          default: ;
        endcase
      end
      // Empty drops while words are queued, set wins on the move
      if (tx_taken)
        tx_empty_flag <= !fifo_out_valid;
      else if (write_tx && fifo_in_ready)
        tx_empty_flag <= 1'b0;
      // A completing word sets full over a simultaneous read; the read still clears overflow
      if (rx_done) begin
        receive_holding  <= rx_word;
        rx_full_flag     <= 1'b1;
        rx_overflow_flag <= rx_full_flag && !read_rx ? 1'b1 :
                            (read_rx ? 1'b0 : rx_overflow_flag);
      end else if (read_rx) begin
        rx_full_flag     <= 1'b0;
        rx_overflow_flag <= 1'b0;
      end
      interrupt_request <= interrupt_setup[`INT_ENABLE_BIT] &&
        (interrupt_setup[`INT_MANUAL_BIT] ||
         (interrupt_setup[`INT_RX_FULL_BIT] && rx_done) ||
         (interrupt_setup[`INT_RX_OVER_BIT] && rx_done &&
          rx_full_flag && !read_rx) ||
         (interrupt_setup[`INT_TX_EMPTY_BIT] && tx_taken));
      tx_dma_request <= transfer_setup[`SETUP_TX_DMA_BIT] && tx_taken;
      rx_dma_request <= transfer_setup[`SETUP_RX_DMA_BIT] && rx_done;
    end
  end

  always @* begin
    next_rdata = `WORD_RESET;
    if (reg_read) begin
      case (reg_addr)
        `RECEIVE_HOLDING_ADDR:      next_rdata = receive_holding;
        // Queue storage is not reset; an empty queue reads as zero
        `TRANSMIT_HOLDING_ADDR:     next_rdata = fifo_out_valid ?
                                                 fifo_out_data :
                                                 `WORD_RESET;
        `TRANSFER_SETUP_ADDR:       next_rdata = transfer_setup;
        `SLAVE_SELECT_CONTROL_ADDR: next_rdata = slave_select_control;
        `INTERWORD_WAIT_ADDR:       next_rdata = interword_wait;
        `TRANSFER_FLAGS_ADDR: begin
          next_rdata[`FLAG_RX_FULL_BIT]  = rx_full_flag;
          next_rdata[`FLAG_RX_OVER_BIT]  = rx_overflow_flag;
          next_rdata[`FLAG_TX_EMPTY_BIT] = tx_empty_flag;
          next_rdata[`FLAG_BUSY_BIT]     = transfer_busy_flag &&
                                           master_mode;
        end
        `INTERRUPT_SETUP_ADDR:      next_rdata = interrupt_setup;
        `RECEIVE_BIT_MASK_ADDR:     next_rdata = receive_bit_mask;
        default:                    next_rdata = `WORD_RESET;
      endcase
    end
  end
endmodule // serial_controller

// file: include/serial_ctl_map.vh
// Register offsets, field positions and reset values of the serial controller
`ifndef SERIAL_CTL_MAP_VH
`define SERIAL_CTL_MAP_VH

`define RECEIVE_HOLDING_ADDR      24'h301700
`define TRANSMIT_HOLDING_ADDR     24'h301704
`define TRANSFER_SETUP_ADDR       24'h301708
`define SLAVE_SELECT_CONTROL_ADDR 24'h30170c
`define INTERWORD_WAIT_ADDR       24'h301710
`define TRANSFER_FLAGS_ADDR       24'h301714
`define INTERRUPT_SETUP_ADDR      24'h301718
`define RECEIVE_BIT_MASK_ADDR     24'h30171c

`define SETUP_ENABLE_BIT    0
`define SETUP_MODE_BIT      1
`define SETUP_RX_DMA_BIT    2
`define SETUP_TX_DMA_BIT    3
`define SETUP_RATE_LSB      4
`define SETUP_RATE_MSB      6
`define SETUP_POLARITY_BIT  8
`define SETUP_PHASE_BIT     9
`define SETUP_LENGTH_LSB    10
`define SETUP_LENGTH_MSB    14
`define SETUP_WRITE_MASK    32'h00007f7f

`define SELECT_BIT          10
`define SELECT_WRITE_MASK   32'h00000400

`define FLAG_RX_FULL_BIT    2
`define FLAG_RX_OVER_BIT    3
`define FLAG_TX_EMPTY_BIT   4
`define FLAG_BUSY_BIT       6

`define INT_ENABLE_BIT      0
`define INT_MANUAL_BIT      1
`define INT_RX_FULL_BIT     2
`define INT_RX_OVER_BIT     3
`define INT_TX_EMPTY_BIT    4
`define INT_WRITE_MASK      32'h0000001f

`define MASK_COUNT_MSB      5
`define MASK_WRITE_MASK     32'h0000003f

`define WORD_RESET          32'h00000000
`define BASE_DIVIDE_HALF    3'h2

`endif

// file: logic/word_fifo.v
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = store[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        store[wr_ptr] <= in_data;
        wr_ptr        <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                         wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // word_fifo

// file: verification/serial_controller_props.sv
// Port-level property checker for the serial controller
`timescale 1ns/1ps
`include "serial_ctl_map.vh"
module serial_controller_props (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Register port
  input wire logic [23:0] reg_addr,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // Serial link
  input wire logic        serial_in_pin,
  input wire logic        serial_out_pin,
  input wire logic        serial_clock_out,
  input wire logic        serial_clock_oe_n,
  input wire logic        serial_clock_in,
  // Requests
  input wire logic        interrupt_request,
  input wire logic        tx_dma_request,
  input wire logic        rx_dma_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rd_rx    = reg_read && reg_addr == `RECEIVE_HOLDING_ADDR;
  wire rd_setup = reg_read && reg_addr == `TRANSFER_SETUP_ADDR;
  wire rd_sel   = reg_read && reg_addr == `SLAVE_SELECT_CONTROL_ADDR;
  wire rd_flags = reg_read && reg_addr == `TRANSFER_FLAGS_ADDR;
  wire rd_int   = reg_read && reg_addr == `INTERRUPT_SETUP_ADDR;
  wire rd_mask  = reg_read && reg_addr == `RECEIVE_BIT_MASK_ADDR;
  wire rd_void  = reg_read && (reg_addr[1:0] != 2'h0 ||
                  reg_addr < 24'h301700 || reg_addr > 24'h30171c);

  setup_rsvd_zero_a: assert property (rd_setup |=>
    (reg_rdata & ~`SETUP_WRITE_MASK) == 32'h0) else $error("setup rsvd");
  select_rsvd_zero_a: assert property (rd_sel |=>
    (reg_rdata & ~`SELECT_WRITE_MASK) == 32'h0) else $error("select rsvd");
  flags_rsvd_zero_a: assert property (rd_flags |=>
    (reg_rdata & ~32'h5c) == 32'h0) else $error("flags rsvd");
  irq_rsvd_zero_a: assert property (rd_int |=>
    (reg_rdata & ~`INT_WRITE_MASK) == 32'h0) else $error("irq rsvd");
  mask_rsvd_zero_a: assert property (rd_mask |=>
    (reg_rdata & ~`MASK_WRITE_MASK) == 32'h0) else $error("mask rsvd");
  unmapped_read_a: assert property (rd_void |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  read_clears_a: assert property (rd_rx ##2 rd_flags |=>
    reg_rdata[3:2] == 2'h0) else $error("flags not cleared by read");
  busy_idle_zero_a: assert property (rd_flags && serial_clock_oe_n &&
    $past(serial_clock_oe_n) |=> !reg_rdata[6]) else $error("busy set");
  clock_half_min_a: assert property ($changed(serial_clock_out) |=>
    $stable(serial_clock_out)) else $error("serial clock too fast");
  tx_dma_pulse_a: assert property (tx_dma_request |=>
    !tx_dma_request) else $error("tx request longer than a cycle");
  rx_dma_pulse_a: assert property (rx_dma_request |=>
    !rx_dma_request) else $error("rx request longer than a cycle");

  cover property (rx_dma_request);
  cover property (tx_dma_request && !serial_clock_oe_n);
  cover property (rd_flags ##1 reg_rdata[3]);
endmodule // serial_controller_props

bind serial_controller serial_controller_props i_serial_controller_props (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_clock_out(serial_clock_out),
  .serial_clock_oe_n(serial_clock_oe_n),
  .serial_clock_in(serial_clock_in), .interrupt_request(interrupt_request),
  .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request)
);

// file: verification/serial_peer_model.sv
// Echo peer on the serial link: sends back the previous word it took in
`timescale 1ns/1ps
module serial_peer_model (
  // Clock
  input  wire logic        clock,
  // Serial link
  input  wire logic        link_clock,
  input  wire logic        link_clock_oe_n,
  input  wire logic        data_from_ctl,
  output wire logic        data_to_ctl,
  // Bench control
  input  wire logic        load,
  input  wire logic [31:0] preload,
  input  wire logic [5:0]  word_bits,
  output logic      [31:0] shift_word
);
  logic prev_clock = 1'b0;
  logic drive_bit  = 1'b0;
  // Polarity 0, phase 0 only: take on rise, move on fall
  always @(posedge clock) begin
    prev_clock <= link_clock;
    if (load) begin
      shift_word <= preload;
      drive_bit  <= preload[word_bits - 6'd1];
    end else if (link_clock && !prev_clock) begin
      shift_word <= {shift_word[30:0], data_from_ctl};
    end else if (!link_clock && prev_clock) begin
      drive_bit <= shift_word[word_bits - 6'd1];
    end
  end
  // Released line shows the inverse, never a held copy
  assign data_to_ctl = link_clock_oe_n ? ~drive_bit : drive_bit;
endmodule // serial_peer_model

// file: verification/serial_controller_bench.sv
// Self-checking bench for the serial controller against an echo peer
`timescale 1ns/1ps
`include "serial_ctl_map.vh"
module serial_controller_bench;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [23:0] reg_addr = 24'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic        serial_clock_in = 1'b0;
  logic        peer_load = 1'b0;
  logic [31:0] peer_preload = 32'h0;
  logic [5:0]  peer_bits = 6'd8;
  wire  [31:0] reg_rdata;
  wire  [31:0] peer_word;
  wire         serial_in_pin, serial_out_pin, serial_clock_out;
  wire         serial_clock_oe_n, interrupt_request;
  wire         tx_dma_request, rx_dma_request;
  int          err_count = 0, n_compared = 0, seed = 32'h4115a42f;
  int          rate_now = 0, high_len = 0, words = 0;
  int          irq_seen = 0, tx_seen = 0, rx_seen = 0, n, m;
  int          len_tab [4] = '{8, 32, 1, 17};
  int          rate_tab [4] = '{0, 1, 0, 2};
  int          mask_tab [4] = '{0, 4, 0, 33};
  logic [23:0] rw_addr [5] = '{24'h301708, 24'h30170c, 24'h301718,
                               24'h30171c, 24'h301710};
  logic [31:0] rw_val [5] = '{32'h7f7e, 32'h400, 32'h1e, 32'h3f,
                              32'h12345678};
  logic [31:0] q, tx, echo;
  logic [31:0] sent [$];

  always #12.5 clock = ~clock;

  serial_controller i_serial_controller (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_clock_out(serial_clock_out),
    .serial_clock_oe_n(serial_clock_oe_n),
    .serial_clock_in(serial_clock_in),
    .interrupt_request(interrupt_request),
    .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request));

  serial_peer_model i_serial_peer_model (.clock(clock),
    .link_clock(serial_clock_out), .link_clock_oe_n(serial_clock_oe_n),
    .data_from_ctl(serial_out_pin), .data_to_ctl(serial_in_pin),
    .load(peer_load), .preload(peer_preload), .word_bits(peer_bits),
    .shift_word(peer_word));

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // High time of the serial clock, checked when it falls
  always @(posedge clock) begin
    // Only while driven: a disabled master parks at the polarity level
    high_len <= (serial_clock_out && !serial_clock_oe_n) ? high_len + 1 : 0;
    if (rst_n && !serial_clock_oe_n && !serial_clock_out && high_len > 0)
      check("clock high time", high_len, 2 << rate_now);
    irq_seen <= irq_seen + $rose(interrupt_request);
    tx_seen <= tx_seen + tx_dma_request;
    rx_seen <= rx_seen + rx_dma_request;
  end

  task automatic acc(input logic wr, input logic [23:0] a,
                     input logic [31:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = wr;
    reg_read = !wr;
    @(negedge clock);
    reg_write = 1'b0;
    reg_read = 1'b0;
    q = reg_rdata;
  endtask

  task automatic rd(input logic [23:0] a, input logic [31:0] exp,
                    input string what);
    acc(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask

  task automatic setup_on(input logic [31:0] v);
    acc(1'b1, `TRANSFER_SETUP_ADDR, v);
    acc(1'b1, `TRANSFER_SETUP_ADDR, v | 32'h1);
  endtask

  // Wait for the landing count, then for busy to drop
  task automatic settle(input int target);
    for (int i = 0; i < 20000 && rx_seen < target; i++)
      @(negedge clock);
    for (int i = 0; i < 200; i++) begin
      acc(1'b0, `TRANSFER_FLAGS_ADDR, 32'h0);
      if (q[6] === 1'b0)
        break;
    end
  endtask

  function automatic logic [31:0] low_bits(input int k);
    low_bits = (k >= 32) ? 32'hffffffff : (32'h1 << k) - 32'h1;
  endfunction

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    err_count++;
    give_verdict;
  end

  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++)
      rd(24'h301700 + 24'(4 * i), i == 5 ? 32'h10 : 32'h0, "reset");
    acc(1'b1, `RECEIVE_HOLDING_ADDR, 32'hdeadbeef);
    rd(`RECEIVE_HOLDING_ADDR, 32'h0, "rx holding write");
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, rw_addr[i], rw_val[i]);
      rd(rw_addr[i], rw_val[i], "readback");
      acc(1'b1, rw_addr[i], 32'h0);
    end
    // Master words over a spread of lengths, rates and masks
    for (int c = 0; c < 4; c++) begin
      n = len_tab[c];
      m = mask_tab[c];
      acc(1'b1, `TRANSFER_SETUP_ADDR, 32'h0);
      acc(1'b1, `RECEIVE_BIT_MASK_ADDR, m);
      acc(1'b1, `INTERRUPT_SETUP_ADDR, c == 0 ? 32'h4 : 32'h5);
      peer_bits = n;
      peer_preload = $random(seed);
      peer_load = 1'b1;
      @(negedge clock);
      peer_load = 1'b0;
      echo = peer_preload & low_bits(n);
      rate_now = rate_tab[c];
      setup_on(((n - 1) << 10) | (rate_now << 4) | 32'he);
      tx = $random(seed);
      acc(1'b1, `TRANSMIT_HOLDING_ADDR, tx);
      words++;
      if (n >= 8) begin
        repeat (4) @(negedge clock);
        rd(`TRANSFER_FLAGS_ADDR, 32'h50, "busy mid word");
      end
      settle(words);
      q = peer_word & low_bits(n);
      check("peer got", q, tx & low_bits(n));
      rd(`TRANSFER_FLAGS_ADDR, 32'h14, "flags after word");
      rd(`RECEIVE_HOLDING_ADDR, echo & low_bits(m > 32 ? 0 : 32 - m),
         "received word");
      rd(`TRANSFER_FLAGS_ADDR, 32'h10, "flags after read");
    end
    // Fill the queue past its depth, then drain with no reads
    acc(1'b1, `TRANSFER_SETUP_ADDR, 32'h0);
    acc(1'b1, `RECEIVE_BIT_MASK_ADDR, 32'h0);
    peer_bits = 6'd8;
    rate_now = 0;
    for (int k = 0; k < 17; k++) begin
      sent.push_back($random(seed));
      acc(1'b1, `TRANSMIT_HOLDING_ADDR, sent[k]);
    end
    rd(`TRANSFER_FLAGS_ADDR, 32'h0, "flags queue full");
    setup_on(32'h1c0e);
    words += 16;
    settle(words);
    rd(`TRANSFER_FLAGS_ADDR, 32'h1c, "flags overflow");
    rd(`RECEIVE_HOLDING_ADDR, sent[14] & 32'hff, "last word");
    check("tx requests", tx_seen, words);
    check("rx requests", rx_seen, words);
    check("interrupts", irq_seen, words - 1);
    // Slave: word waits for the remote clock
    acc(1'b1, `TRANSFER_SETUP_ADDR, 32'h0);
    acc(1'b1, `SLAVE_SELECT_CONTROL_ADDR, 32'h400);
    acc(1'b1, `TRANSFER_SETUP_ADDR, 32'h1c01);
    acc(1'b1, `TRANSMIT_HOLDING_ADDR, 32'h5a);
    repeat (10) @(negedge clock);
    rd(`TRANSFER_FLAGS_ADDR, 32'h0, "slave before clock");
    for (int b = 0; b < 16; b++) begin
      repeat (4) @(negedge clock);
      serial_clock_in = ~serial_clock_in;
    end
    repeat (10) @(negedge clock);
    rd(`TRANSFER_FLAGS_ADDR, 32'h14, "slave after clock");
    check("slave clock drive", serial_clock_oe_n, 32'h1);
    give_verdict;
  end
endmodule // serial_controller_bench
